//--- src/bcs_bootload_control.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"

module bcs_bootload_control (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register port
	input wire bcs_pkg::bcs_addr_t reg_addr,
	input wire bcs_pkg::bcs_byte_t reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output bcs_pkg::bcs_byte_t reg_rd_data,
	// bootload data
	input wire logic load_valid,
	input wire bcs_pkg::bcs_addr_t load_addr,
	input wire bcs_pkg::bcs_byte_t load_data,
	// core fetch
	input wire bcs_pkg::bcs_addr_t fetch_addr,
	input wire bcs_pkg::bcs_byte_t rom_data,
	output bcs_pkg::bcs_byte_t fetch_data,
	output logic fetch_from_ram,
	// mode status
	output logic boot_mode,
	output bcs_pkg::bcs_mode_e run_mode
);

	import bcs_pkg::*;

	////////////////////////////////////////////////////////////////
	// register decode

	function automatic logic hit(input bcs_addr_t addr, input bcs_addr_t ofs);
		return addr == ofs;
	endfunction

	logic ctl_wr;
	logic chk_rd;
	assign ctl_wr = reg_wr && hit(reg_addr, `BCS_OFS_CONTROL);
	assign chk_rd = reg_rd && hit(reg_addr, `BCS_OFS_CHECK);

	////////////////////////////////////////////////////////////////
	// control register

	localparam bcs_byte_t ctl_rst_val = `BCS_RST_CONTROL;

	logic code_memory_select_reg;
	logic boot_reg;

	// reserved bits are not stored and read back as zero
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			code_memory_select_reg <= ctl_rst_val[`BCS_BIT_SELECT];
			boot_reg <= ctl_rst_val[`BCS_BIT_BOOT];
		end else if (ctl_wr) begin
			code_memory_select_reg <= reg_wr_data[`BCS_BIT_SELECT];
			boot_reg <= reg_wr_data[`BCS_BIT_BOOT];
		end
	end

	////////////////////////////////////////////////////////////////
	// bootload data path

	logic load_fire;
	assign load_fire = load_valid && boot_reg;

	bcs_byte_t load_count_reg;

	// restarts on each entry into bootload mode
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			load_count_reg <= `BCS_RST_COUNT;
		end else if (!boot_reg) begin
			load_count_reg <= `BCS_RST_COUNT;
		end else if (load_fire) begin
			load_count_reg <= load_count_reg + 8'h01;
		end
	end

	bcs_byte_t ram_q;

	bcs_program_ram u_ram (
		.sys_clk(sys_clk),
		.wr_en(load_fire),
		.wr_addr(load_addr),
		.wr_data(load_data),
		.rd_addr(fetch_addr),
		.rd_data(ram_q)
	);

	bcs_byte_t check_value;

	bcs_check_value u_check (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.boot_en(boot_reg),
		.data_valid(load_fire),
		.data_in(load_data),
		.check_value(check_value)
	);

	////////////////////////////////////////////////////////////////
	// fetch path

	bcs_byte_t rom_data_reg;
	logic select_dly_reg;

	// rom path delayed to line up with the ram read register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rom_data_reg <= `BCS_RST_BYTE;
			select_dly_reg <= 1'b0;
		end else begin
			rom_data_reg <= rom_data;
			select_dly_reg <= code_memory_select_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fetch_data <= `BCS_RST_BYTE;
		end else begin
			fetch_data <= select_dly_reg ? ram_q : rom_data_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fetch_from_ram <= 1'b0;
			boot_mode <= 1'b0;
		end else begin
			fetch_from_ram <= code_memory_select_reg;
			boot_mode <= boot_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// run mode status

	bcs_mode_e mode_next;

	always_comb begin
		unique case ({boot_reg, code_memory_select_reg})
			2'b10, 2'b11: mode_next = BCS_LOADING;
			2'b01: mode_next = BCS_RUN_RAM;
			2'b00: mode_next = BCS_RUN_ROM;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			run_mode <= BCS_RUN_ROM;
		end else begin
			run_mode <= mode_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// read data

	bcs_byte_t rd_next;

	always_comb begin
		rd_next = `BCS_RST_BYTE;
		if (reg_rd) begin
			if (hit(reg_addr, `BCS_OFS_CONTROL)) begin
				rd_next[`BCS_BIT_SELECT] = code_memory_select_reg;
				rd_next[`BCS_BIT_BOOT] = boot_reg;
			end else if (hit(reg_addr, `BCS_OFS_CHECK)) begin
				rd_next = boot_reg ? check_value : `BCS_RST_BYTE;
			end else if (hit(reg_addr, `BCS_OFS_COUNT)) begin
				rd_next = load_count_reg;
			end
		end
	end

	// holds data only in the cycle after a read
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rd_data <= `BCS_RST_BYTE;
		end else begin
			reg_rd_data <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions

	property p_select_reaches_fetch;
		@(posedge sys_clk) disable iff (!rst_n)
		ctl_wr |=> ##2 fetch_data == ($past(reg_wr_data[`BCS_BIT_SELECT], 3)
			? $past(ram_q) : $past(rom_data_reg));
	endproperty
	a_select_reaches_fetch: assert property (p_select_reaches_fetch)
		else $error("fetch source does not follow select bit");

	property p_flag_follows_write;
		@(posedge sys_clk) disable iff (!rst_n)
		ctl_wr |=> ##1 (fetch_from_ram == $past(reg_wr_data[`BCS_BIT_SELECT], 2)
			&& boot_mode == $past(reg_wr_data[`BCS_BIT_BOOT], 2));
	endproperty
	a_flag_follows_write: assert property (p_flag_follows_write)
		else $error("mode outputs do not follow control write");

	property p_no_load_when_off;
		@(posedge sys_clk) disable iff (!rst_n)
		!boot_reg && load_valid |=> load_count_reg == `BCS_RST_COUNT;
	endproperty
	a_no_load_when_off: assert property (p_no_load_when_off)
		else $error("load accepted while bootload off");

	property p_check_moves_on_load;
		@(posedge sys_clk) disable iff (!rst_n)
		boot_reg && $past(boot_reg) && $changed(check_value) |-> $past(load_fire);
	endproperty
	a_check_moves_on_load: assert property (p_check_moves_on_load)
		else $error("check value changed without a load");

	property p_first_load_changes;
		@(posedge sys_clk) disable iff (!rst_n)
		load_fire && check_value == `BCS_RST_CHECK && load_data == 8'h00
			|=> check_value == 8'hF3;
	endproperty
	a_first_load_changes: assert property (p_first_load_changes)
		else $error("check value wrong after zero byte from seed");

	property p_check_read_gated;
		@(posedge sys_clk) disable iff (!rst_n)
		chk_rd |=> reg_rd_data == ($past(boot_reg) ? $past(check_value) : 8'h00);
	endproperty
	a_check_read_gated: assert property (p_check_read_gated)
		else $error("check register read not gated by boot bit");

	property p_seed_held;
		@(posedge sys_clk) disable iff (!rst_n)
		!boot_reg ##1 !boot_reg |=> check_value == 8'hFF && $stable(check_value);
	endproperty
	a_seed_held: assert property (p_seed_held)
		else $error("check value not held at seed while bootload off");

	property p_read_one_cycle;
		@(posedge sys_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rd_data == 8'h00;
	endproperty
	a_read_one_cycle: assert property (p_read_one_cycle)
		else $error("read data present without a read");

	property p_load_counts;
		@(posedge sys_clk) disable iff (!rst_n)
		load_fire |=> load_count_reg == $past(load_count_reg) + 8'h01;
	endproperty
	a_load_counts: assert property (p_load_counts)
		else $error("load count did not advance on an accepted byte");

	property p_check_clears_on_exit;
		@(posedge sys_clk) disable iff (!rst_n)
		$fell(boot_reg) |=> check_value == `BCS_RST_CHECK;
	endproperty
	a_check_clears_on_exit: assert property (p_check_clears_on_exit)
		else $error("check value not back at seed after leaving bootload");

	property p_rom_when_clear;
		@(posedge sys_clk) disable iff (!rst_n)
		rst_n && !code_memory_select_reg |=> ##1 fetch_data == $past(rom_data, 2);
	endproperty
	a_rom_when_clear: assert property (p_rom_when_clear)
		else $error("fetch not served from rom while select bit clear");

	property p_ram_when_set;
		@(posedge sys_clk) disable iff (!rst_n)
		rst_n && code_memory_select_reg |=> ##1 fetch_data == $past(ram_q);
	endproperty
	a_ram_when_set: assert property (p_ram_when_set)
		else $error("fetch not served from ram while select bit set");

	property p_loading_status;
		@(posedge sys_clk) disable iff (!rst_n)
		(run_mode == BCS_LOADING) == boot_mode;
	endproperty
	a_loading_status: assert property (p_loading_status)
		else $error("run mode disagrees with bootload status");

	property p_ram_status;
		@(posedge sys_clk) disable iff (!rst_n)
		(run_mode == BCS_RUN_RAM) == (fetch_from_ram && !boot_mode);
	endproperty
	a_ram_status: assert property (p_ram_status)
		else $error("run mode disagrees with fetch source");

	c_load_in_boot: cover property (@(posedge sys_clk) disable iff (!rst_n)
		load_fire ##1 load_fire);
	c_check_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
		chk_rd && boot_reg && check_value != 8'hFF);
	c_run_from_ram: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(fetch_from_ram) && !boot_mode);
	c_boot_exit: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(boot_reg));
	c_read_after_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
		ctl_wr ##2 chk_rd);

endmodule // bcs_bootload_control
`default_nettype wire

//--- src/bcs_defines.svh
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

// register offsets
`define BCS_OFS_CONTROL 8'h00
`define BCS_OFS_CHECK 8'h01
`define BCS_OFS_COUNT 8'h02

// control register fields
`define BCS_BIT_SELECT 3
`define BCS_BIT_BOOT 2

// reset values
`define BCS_RST_CONTROL 8'h00
`define BCS_RST_CHECK 8'hFF
`define BCS_RST_COUNT 8'h00
`define BCS_RST_BYTE 8'h00

// check value polynomial
`define BCS_CHECK_POLY 8'h07

// program memory depth
`define BCS_MEM_DEPTH 256

`endif

//--- src/bcs_pkg.sv
package bcs_pkg;

	typedef logic [7:0] bcs_byte_t;
	typedef logic [7:0] bcs_addr_t;

	typedef enum logic [1:0] {
		BCS_RUN_ROM,
		BCS_LOADING,
		BCS_RUN_RAM
	} bcs_mode_e;

endpackage

//--- src/bcs_program_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"

module bcs_program_ram (
	// clock
	input wire logic sys_clk,
	// write side
	input wire logic wr_en,
	input wire bcs_pkg::bcs_addr_t wr_addr,
	input wire bcs_pkg::bcs_byte_t wr_data,
	// read side
	input wire bcs_pkg::bcs_addr_t rd_addr,
	output bcs_pkg::bcs_byte_t rd_data
);

	import bcs_pkg::*;

	bcs_byte_t mem [`BCS_MEM_DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		rd_data <= mem[rd_addr];
	end

endmodule // bcs_program_ram
`default_nettype wire

//--- src/bcs_check_value.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"

module bcs_check_value (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// control
	input wire logic boot_en,
	input wire logic data_valid,
	input wire bcs_pkg::bcs_byte_t data_in,
	// result
	output bcs_pkg::bcs_byte_t check_value
);

	import bcs_pkg::*;

	bcs_byte_t check_reg;
	bcs_byte_t check_next;

	// one byte of crc-8, msb first
	function automatic bcs_byte_t crc_step(input bcs_byte_t crc, input bcs_byte_t data);
		bcs_byte_t c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ `BCS_CHECK_POLY) : (c << 1);
		end
		return c;
	endfunction

	always_comb begin
		check_next = check_reg;
		if (!boot_en) begin
			check_next = `BCS_RST_CHECK;
		end else if (data_valid) begin
			check_next = crc_step(check_reg, data_in);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			check_reg <= `BCS_RST_CHECK;
		end else begin
			check_reg <= check_next;
		end
	end

	assign check_value = check_reg;

endmodule // bcs_check_value
`default_nettype wire

//--- tb/bcs_bootload_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"

module bcs_bootload_control_tb;
	import bcs_pkg::*;
	logic sys_clk, rst_n, reg_wr, reg_rd, load_valid, fetch_from_ram, boot_mode;
	bcs_addr_t reg_addr, load_addr, fetch_addr;
	bcs_byte_t reg_wr_data, reg_rd_data, load_data, rom_data, fetch_data, exp_chk;
	bcs_mode_e run_mode;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;

	bcs_bootload_control DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
		.load_valid(load_valid), .load_addr(load_addr), .load_data(load_data),
		.fetch_addr(fetch_addr), .rom_data(rom_data), .fetch_data(fetch_data),
		.fetch_from_ram(fetch_from_ram), .boot_mode(boot_mode), .run_mode(run_mode));

	////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count = err_count + 1;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// reference check value step, msb first
	function automatic bcs_byte_t crc_step(input bcs_byte_t c, input bcs_byte_t d);
		bcs_byte_t v;
		v = c ^ d;
		for (int i = 0; i < 8; i++) begin
			v = v[7] ? ((v << 1) ^ `BCS_CHECK_POLY) : (v << 1);
		end
		return v;
	endfunction

	task automatic wr(input bcs_addr_t a, input bcs_byte_t d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input bcs_addr_t a, input bcs_byte_t exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rd_data, exp);
	endtask

	// wait for the registered mode outputs to follow a control write
	task automatic mode_chk(input logic ram, input logic boot, input bcs_mode_e m);
		@(posedge sys_clk);
		#1 chk({7'h00, fetch_from_ram}, {7'h00, ram});
		chk({7'h00, boot_mode}, {7'h00, boot});
		chk({6'h00, run_mode}, {6'h00, m});
	endtask

	task automatic load_run(input int n, input bcs_byte_t base);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			load_valid <= 1'b1;
			load_addr <= i[7:0];
			load_data <= base + i[7:0];
		end
		@(posedge sys_clk);
		load_valid <= 1'b0;
	endtask

	task automatic fetch_chk(input bcs_addr_t a, input bcs_byte_t rom, input bcs_byte_t exp);
		@(posedge sys_clk);
		fetch_addr <= a;
		rom_data <= rom;
		@(posedge sys_clk);
		@(posedge sys_clk);
		#1 chk(fetch_data, exp);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		mode_chk(1'b0, 1'b0, BCS_RUN_ROM);
		rd_chk(`BCS_OFS_CONTROL, 8'h00);
		rd_chk(`BCS_OFS_CHECK, 8'h00);
		rd_chk(`BCS_OFS_COUNT, 8'h00);
		rd_chk(8'h05, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_ctrl();
		wr(`BCS_OFS_CONTROL, 8'hF4);
		mode_chk(1'b0, 1'b1, BCS_LOADING);
		rd_chk(`BCS_OFS_CONTROL, 8'h04);
		rd_chk(`BCS_OFS_CHECK, 8'hFF);
		@(posedge sys_clk);
		#1 chk(reg_rd_data, 8'h00);
		wr(`BCS_OFS_CHECK, 8'h55);
		rd_chk(`BCS_OFS_CHECK, 8'hFF);
		$display("test control done");
	endtask

	task automatic t_load();
		exp_chk = 8'hFF;
		for (int i = 0; i < 5; i++) begin
			exp_chk = crc_step(exp_chk, i[7:0]);
		end
		load_run(5, 8'h00);
		rd_chk(`BCS_OFS_CHECK, exp_chk);
		rd_chk(`BCS_OFS_COUNT, 8'h05);
		wr(`BCS_OFS_CONTROL, 8'h0C);
		mode_chk(1'b1, 1'b1, BCS_LOADING);
		$display("test load done");
	endtask

	task automatic t_hold();
		wr(`BCS_OFS_CONTROL, 8'h00);
		mode_chk(1'b0, 1'b0, BCS_RUN_ROM);
		rd_chk(`BCS_OFS_CHECK, 8'h00);
		load_run(3, 8'hA0);
		wr(`BCS_OFS_CONTROL, 8'h04);
		rd_chk(`BCS_OFS_CHECK, 8'hFF);
		rd_chk(`BCS_OFS_COUNT, 8'h00);
		$display("test hold done");
	endtask

	task automatic t_fetch();
		wr(`BCS_OFS_CONTROL, 8'h08);
		mode_chk(1'b1, 1'b0, BCS_RUN_RAM);
		for (int i = 0; i < 5; i++) begin
			fetch_chk(i[7:0], 8'h3C, i[7:0]);
		end
		wr(`BCS_OFS_CONTROL, 8'h00);
		mode_chk(1'b0, 1'b0, BCS_RUN_ROM);
		fetch_chk(8'h02, 8'h5A, 8'h5A);
		$display("test fetch done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
		load_valid = 1'b0;
		load_addr = 8'h00;
		load_data = 8'h00;
		fetch_addr = 8'h00;
		rom_data = 8'h00;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_ctrl();
		t_load();
		t_hold();
		t_fetch();
		summarize();
	end
endmodule // bcs_bootload_control_tb
`default_nettype wire
